// >>> sim/iosr_bank_monitor.sv
// Purpose: Port checker for the override status bank.
// Assumes: Each answer comes exactly one cycle after its request.
// Notes: Override checks watch the analog input group.
`timescale 1ns/10ps
`default_nettype none
module iosr_bank_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire iosr_pkg::iosr_req_t req,
	input wire logic rsp_valid,
	input wire iosr_pkg::iosr_rsp_t rsp,
	input wire iosr_pkg::iosr_status_t status,
	input wire logic force_valid,
	input wire iosr_pkg::iosr_force_t force_req,
	input wire logic [iosr_pkg::GROUP_COUNT-1:0][5:0] remote_force_active,
	input wire logic [iosr_pkg::GROUP_COUNT-1:0][5:0] override_select
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	logic fok;
	logic rd;
	assign fok = req.func inside {8'h03, 8'h06, 8'h10};
	assign rd = req_valid && req.func == 8'h03;
	property p_lat;
		req_valid |=> rsp_valid;
	endproperty
	a_lat: assert property (p_lat) else $error("answer missing");
	property p_idle;
		!req_valid |=> !rsp_valid;
	endproperty
	a_idle: assert property (p_idle) else $error("stray answer");
	property p_func;
		req_valid && !fok |=> rsp.exc == 8'h01 && rsp.rdata == 16'h0000;
	endproperty
	a_func: assert property (p_func) else $error("bad code taken");
	property p_addr;
		req_valid && fok && !(req.addr inside {[16'h9C40:16'hA027]})
			|=> rsp.exc == 8'h02;
	endproperty
	a_addr: assert property (p_addr) else $error("address taken");
	property p_unused;
		rd && req.addr inside {[16'h9C53:16'hA027]} |=> rsp.rdata == 16'h0000;
	endproperty
	a_unused: assert property (p_unused) else $error("unused nonzero");
	property p_inw;
		rd && req.addr inside {[16'h9C40:16'h9C4A]} |=> rsp.rdata[15:6] == 10'h000;
	endproperty
	a_inw: assert property (p_inw) else $error("input word high bits");
	property p_outw;
		rd && req.addr inside {[16'h9C4B:16'h9C52]} |=> rsp.rdata[15:4] == 12'h000;
	endproperty
	a_outw: assert property (p_outw) else $error("output word high bits");
	property p_cancel;
		(remote_force_active[0] & $past(status.analog_in_local, 2)) == 6'h00;
	endproperty
	a_cancel: assert property (p_cancel) else $error("override kept");
	property p_sel;
		(remote_force_active[0] & ~override_select[0]) == 6'h00;
	endproperty
	a_sel: assert property (p_sel) else $error("value path not forced");
	property p_rise;
		$rose(remote_force_active[0][2]) |-> $past(force_valid);
	endproperty
	a_rise: assert property (p_rise) else $error("override without event");
	c_write: cover property (req_valid && req.func == 8'h10);
	c_exc: cover property (rsp_valid && rsp.exc == 8'h02);
	c_force: cover property ($rose(remote_force_active[0][2]));
endmodule // iosr_bank_monitor
`default_nettype wire

// >>> sim/iosr_client.sv
// Purpose: Request-side model of the remote client of the bank.
// Assumes: One word per request, taken on the rising edge.
// Notes: Drives at the falling edge and scrambles the lines once released.
`timescale 1ns/10ps
`default_nettype none
module iosr_client (
	input wire logic clk,
	output logic req_valid,
	output iosr_pkg::iosr_req_t req
);
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, d);
		@(negedge clk);
		req_valid = 1'b1;
		req = '{func: f, addr: a, wdata: d};
		@(negedge clk);
		req_valid = 1'b0;
		req = ~req;
	endtask
endmodule // iosr_client
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench for the override status bank.
// Assumes: Fixed one-cycle answers, so no handshake waits are needed.
// Notes: Inputs change at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk, reset, req_valid, rsp_valid, force_valid;
	iosr_pkg::iosr_req_t req;
	iosr_pkg::iosr_rsp_t rsp;
	iosr_pkg::iosr_status_t status;
	iosr_pkg::iosr_force_t force_req;
	logic [5:0][5:0] rfa, sel;
	int mismatches, checks;
	iosr_client cli (.clk(clk), .req_valid(req_valid), .req(req));
	iosr_bank dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
		.rsp_valid(rsp_valid), .rsp(rsp), .status(status),
		.force_valid(force_valid), .force_req(force_req),
		.remote_force_active(rfa), .override_select(sel));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic acc(input logic [7:0] f, input logic [15:0] a, d, e,
		input logic [7:0] x);
		// The answer stands from the edge that takes the request until the
		// next edge, so it is judged at the falling edge in between.
		cli.xfer(f, a, d);
		chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
		chk("exc", {8'h00, x}, {8'h00, rsp.exc});
		if (x != 8'h02) begin
			chk("rdata", e, rsp.rdata);
		end
	endtask
	task automatic frc(input logic [2:0] g, c, input logic ok, e);
		@(negedge clk);
		force_valid = 1'b1;
		force_req = '{group: g, channel: c, value_ok: ok};
		@(negedge clk);
		force_valid = 1'b0;
		chk("active", {15'h0000, e}, {15'h0000, rfa[g][c]});
	endtask
	task automatic t_regs;
		logic [5:0] s[19];
		logic [15:0] a;
		status = 66'h1_A55A_3CC3_F00F_96C3;
		s = '{status.analog_in_range, status.count_in_range, status.rate_in_range,
			status.analog_in_local, status.switch_in_local, status.count_in_local,
			status.rate_in_local, 6'h00, 6'h00, 6'h00, 6'h00,
			{2'b00, status.analog_out_local}, {2'b00, status.digital_out_local},
			{2'b00, status.analog_out_alarm}, {2'b00, status.digital_out_alarm},
			{2'b00, status.analog_out_recopy}, {2'b00, status.digital_out_recopy},
			6'h00, 6'h00};
		for (int i = 0; i < 19; i++) begin
			acc(8'h03, 16'h9C40 + 16'(i), 16'h0000, {10'h000, s[i]}, 8'h00);
		end
		acc(8'h06, 16'h9C40, 16'hFFFF, 16'hFFFF, 8'h00);
		acc(8'h03, 16'h9C40, 16'h0000, {10'h000, s[0]}, 8'h00);
		for (int g = 0; g < 6; g++) begin
			a = (g < 4) ? 16'h9C47 + 16'(g) : 16'h9C4D + 16'(g);
			for (int i = 0; i < 6; i++) begin
				acc(8'h10, a, 16'h0001 << i, 16'h0001 << i, 8'h00);
				acc(8'h03, a, 16'h0000, (g < 4 || i < 4) ? 16'h0001 << i : 16'h0000, 8'h00);
			end
			acc(8'h06, a, 16'hFFFF, 16'hFFFF, 8'h00);
			acc(8'h03, a, 16'h0000, (g < 4) ? 16'h003F : 16'h000F, 8'h00);
			acc(8'h06, a, 16'h0000, 16'h0000, 8'h00);
			acc(8'h03, a, 16'h0000, 16'h0000, 8'h00);
		end
		acc(8'h06, 16'hA027, 16'h1234, 16'h1234, 8'h00);
		acc(8'h03, 16'hA027, 16'h0000, 16'h0000, 8'h00);
		acc(8'h03, 16'hA028, 16'h0000, 16'h0000, 8'h02);
		acc(8'h04, 16'h9C40, 16'h0000, 16'h0000, 8'h01);
		$display("t_regs done");
	endtask
	task automatic t_force;
		status = '0;
		acc(8'h06, 16'h9C47, 16'h0014, 16'h0014, 8'h00);
		frc(3'h0, 3'h2, 1'b1, 1'b1);
		chk("select", 16'h0001, {15'h0000, sel[0][2]});
		frc(3'h0, 3'h4, 1'b0, 1'b0);
		frc(3'h0, 3'h0, 1'b1, 1'b0);
		status.analog_in_local = 6'h04;
		repeat (2) @(negedge clk);
		chk("cancel", 16'h0000, {15'h0000, rfa[0][2]});
		frc(3'h0, 3'h2, 1'b1, 1'b0);
		status = '0;
		acc(8'h06, 16'h9C52, 16'h0001, 16'h0001, 8'h00);
		status.digital_out_alarm = 4'h1;
		@(negedge clk);
		frc(3'h5, 3'h0, 1'b1, 1'b0);
		status.digital_out_alarm = 4'h0;
		frc(3'h5, 3'h0, 1'b1, 1'b1);
		acc(8'h06, 16'h9C52, 16'h0000, 16'h0000, 8'h00);
		@(negedge clk);
		chk("disabled", 16'h0000, {15'h0000, rfa[5][0]});
		$display("t_force done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		force_valid = 1'b0;
		force_req = '0;
		status = '0;
		mismatches = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		t_regs;
		t_force;
		end_sim;
	end
endmodule // tb
bind iosr_bank iosr_bank_monitor mon (.clk(clk), .reset(reset),
	.req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
	.status(status), .force_valid(force_valid), .force_req(force_req),
	.remote_force_active(remote_force_active),
	.override_select(override_select));
`default_nettype wire

// >>> verilog/iosr_bank.sv
// Purpose: Holding-register bank 40000-40999 with remote override arbitration.
// Assumes: Requests and status inputs are synchronous to clk.
// Notes: One answer per request, one cycle after it is taken.
`timescale 1ns/10ps
`default_nettype none
module iosr_bank (
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire iosr_pkg::iosr_req_t req,
	output logic rsp_valid,
	output iosr_pkg::iosr_rsp_t rsp,
	input wire iosr_pkg::iosr_status_t status,
	input wire logic force_valid,
	input wire iosr_pkg::iosr_force_t force_req,
	output logic [iosr_pkg::GROUP_COUNT-1:0][5:0] remote_force_active,
	output logic [iosr_pkg::GROUP_COUNT-1:0][5:0] override_select
);
	logic [iosr_pkg::GROUP_COUNT-1:0][5:0] enable;
	logic [iosr_pkg::GROUP_COUNT-1:0][5:0] next_enable;
	logic [iosr_pkg::GROUP_COUNT-1:0][5:0] block_vec;
	logic [iosr_pkg::GROUP_COUNT-1:0][5:0] next_active;
	logic [iosr_pkg::GROUP_COUNT-1:0][5:0] local_vec;
	iosr_pkg::iosr_status_t status_q;
	logic func_ok;
	logic addr_in_holding;
	logic addr_in_block;
	logic is_write;
	logic write_hit;
	logic [2:0] write_group;
	logic [15:0] read_word;

	// Returns the group whose enable word sits at addr, or 7 for none.
	function automatic logic [2:0] enable_group(input logic [15:0] addr);
		case (addr)
			iosr_pkg::OFS_ANALOG_IN_REMOTE_FORCE_EN: enable_group = iosr_pkg::GROUP_ANALOG_IN;
			iosr_pkg::OFS_SWITCH_IN_REMOTE_FORCE_EN: enable_group = iosr_pkg::GROUP_SWITCH_IN;
			iosr_pkg::OFS_COUNT_IN_REMOTE_FORCE_EN: enable_group = iosr_pkg::GROUP_COUNT_IN;
			iosr_pkg::OFS_RATE_IN_REMOTE_FORCE_EN: enable_group = iosr_pkg::GROUP_RATE_IN;
			iosr_pkg::OFS_ANALOG_OUT_REMOTE_FORCE_EN: enable_group = iosr_pkg::GROUP_ANALOG_OUT;
			iosr_pkg::OFS_DIGITAL_OUT_REMOTE_FORCE_EN: enable_group = iosr_pkg::GROUP_DIGITAL_OUT;
			default: enable_group = 3'h7;
		endcase
	endfunction

	// Channel width mask of a group.
	function automatic logic [5:0] group_mask(input int g);
		if (g < iosr_pkg::FIRST_OUT_GROUP) begin
			group_mask = iosr_pkg::IN_MASK;
		end else begin
			group_mask = iosr_pkg::OUT_MASK;
		end
	endfunction

	function automatic logic [15:0] in_word(input logic [5:0] v);
		in_word = {10'h000, v & iosr_pkg::IN_MASK};
	endfunction

	function automatic logic [15:0] out_word(input logic [3:0] v);
		out_word = {12'h000, v};
	endfunction

	assign func_ok = (req.func == iosr_pkg::FUNC_READ_HOLDING) ||
		(req.func == iosr_pkg::FUNC_WRITE_SINGLE) ||
		(req.func == iosr_pkg::FUNC_WRITE_MULTIPLE);
	assign addr_in_holding = (req.addr >= iosr_pkg::HOLDING_BASE) &&
		(req.addr <= iosr_pkg::HOLDING_LAST);
	assign addr_in_block = (req.addr >= iosr_pkg::HOLDING_BASE) &&
		(req.addr <= iosr_pkg::BLOCK_LAST);
	assign is_write = (req.func == iosr_pkg::FUNC_WRITE_SINGLE) ||
		(req.func == iosr_pkg::FUNC_WRITE_MULTIPLE);
	assign write_group = enable_group(req.addr);
	// Writes to read-only or unused words are accepted and dropped.
	assign write_hit = req_valid && is_write && (write_group != 3'h7);

	always_comb begin
		case (req.addr)
			iosr_pkg::OFS_ANALOG_IN_RANGE_FAULT: read_word = in_word(status_q.analog_in_range);
			iosr_pkg::OFS_COUNT_IN_RANGE_FAULT: read_word = in_word(status_q.count_in_range);
			iosr_pkg::OFS_RATE_IN_RANGE_FAULT: read_word = in_word(status_q.rate_in_range);
			iosr_pkg::OFS_ANALOG_IN_LOCAL_FORCE: read_word = in_word(status_q.analog_in_local);
			iosr_pkg::OFS_SWITCH_IN_LOCAL_FORCE: read_word = in_word(status_q.switch_in_local);
			iosr_pkg::OFS_COUNT_IN_LOCAL_FORCE: read_word = in_word(status_q.count_in_local);
			iosr_pkg::OFS_RATE_IN_LOCAL_FORCE: read_word = in_word(status_q.rate_in_local);
			iosr_pkg::OFS_ANALOG_IN_REMOTE_FORCE_EN: read_word = in_word(enable[0]);
			iosr_pkg::OFS_SWITCH_IN_REMOTE_FORCE_EN: read_word = in_word(enable[1]);
			iosr_pkg::OFS_COUNT_IN_REMOTE_FORCE_EN: read_word = in_word(enable[2]);
			iosr_pkg::OFS_RATE_IN_REMOTE_FORCE_EN: read_word = in_word(enable[3]);
			iosr_pkg::OFS_ANALOG_OUT_LOCAL_FORCE: read_word = out_word(status_q.analog_out_local);
			iosr_pkg::OFS_DIGITAL_OUT_LOCAL_FORCE: read_word = out_word(status_q.digital_out_local);
			iosr_pkg::OFS_ANALOG_OUT_ALARM_ACTIVE: read_word = out_word(status_q.analog_out_alarm);
			iosr_pkg::OFS_DIGITAL_OUT_ALARM_ACTIVE: read_word = out_word(status_q.digital_out_alarm);
			iosr_pkg::OFS_ANALOG_OUT_RECOPY_ACTIVE: read_word = out_word(status_q.analog_out_recopy);
			iosr_pkg::OFS_DIGITAL_OUT_RECOPY_ACTIVE: read_word = out_word(status_q.digital_out_recopy);
			iosr_pkg::OFS_ANALOG_OUT_REMOTE_FORCE_EN: read_word = out_word(enable[4][3:0]);
			iosr_pkg::OFS_DIGITAL_OUT_REMOTE_FORCE_EN: read_word = out_word(enable[5][3:0]);
			default: read_word = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_q <= '0;
		end else begin
			status_q <= status;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp <= '0;
		end else begin
			rsp_valid <= req_valid;
			if (req_valid) begin
				if (!func_ok) begin
					rsp.rdata <= 16'h0000;
					rsp.exc <= iosr_pkg::EXC_ILLEGAL_FUNCTION;
				end else if (!addr_in_holding || !addr_in_block) begin
					rsp.rdata <= 16'h0000;
					rsp.exc <= iosr_pkg::EXC_ILLEGAL_ADDRESS;
				end else if (is_write) begin
					rsp.rdata <= req.wdata;
					rsp.exc <= iosr_pkg::EXC_NONE;
				end else begin
					rsp.rdata <= read_word;
					rsp.exc <= iosr_pkg::EXC_NONE;
				end
			end
		end
	end

	assign local_vec[0] = status_q.analog_in_local;
	assign local_vec[1] = status_q.switch_in_local;
	assign local_vec[2] = status_q.count_in_local;
	assign local_vec[3] = status_q.rate_in_local;
	assign local_vec[4] = {2'b00, status_q.analog_out_local};
	assign local_vec[5] = {2'b00, status_q.digital_out_local};
	assign block_vec[0] = local_vec[0];
	assign block_vec[1] = local_vec[1];
	assign block_vec[2] = local_vec[2];
	assign block_vec[3] = local_vec[3];
	assign block_vec[4] = local_vec[4] |
		{2'b00, status_q.analog_out_alarm | status_q.analog_out_recopy};
	assign block_vec[5] = local_vec[5] |
		{2'b00, status_q.digital_out_alarm | status_q.digital_out_recopy};

	genvar g;
	generate
		for (g = 0; g < iosr_pkg::GROUP_COUNT; g = g + 1) begin : grp
			logic [5:0] evt;
			always_comb begin
				next_enable[g] = enable[g];
				if (write_hit && (write_group == 3'(g))) begin
					// Bit n governs channel n; zero clears the whole word.
					next_enable[g] = req.wdata[5:0] & group_mask(g);
				end
			end
			always_comb begin
				evt = 6'h00;
				if (force_valid && force_req.value_ok &&
					(force_req.group == 3'(g))) begin
					evt[force_req.channel] = 1'b1;
				end
			end
			// A new override, taken against the current enable, wins over
			// an enable clear in the same cycle; a block always wins.
			assign next_active[g] = ((remote_force_active[g] & next_enable[g]) |
				(evt & enable[g])) & ~block_vec[g] & group_mask(g);
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					enable[g] <= iosr_pkg::ENABLE_RESET;
				end else begin
					enable[g] <= next_enable[g];
				end
			end
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					remote_force_active[g] <= 6'h00;
				end else begin
					remote_force_active[g] <= next_active[g];
				end
			end
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					override_select[g] <= 6'h00;
				end else begin
					override_select[g] <= (next_active[g] | local_vec[g]) &
						group_mask(g);
				end
			end
		end
	endgenerate
endmodule // iosr_bank
`default_nettype wire

// >>> verilog/iosr_pkg.sv
// Purpose: Shared constants and carriers for the override status bank.
// Assumes: Holding addresses arrive as full 16-bit numbers (40000 = 9C40).
// Notes: Six channel groups; groups 0-3 are inputs, 4-5 are outputs.
`default_nettype none
package iosr_pkg;
	localparam logic [7:0] FUNC_READ_HOLDING = 8'h03;
	localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
	localparam logic [7:0] FUNC_WRITE_MULTIPLE = 8'h10;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
	localparam logic [15:0] HOLDING_BASE = 16'h9C40;
	localparam logic [15:0] HOLDING_LAST = 16'hAB9F;
	localparam logic [15:0] BLOCK_LAST = 16'hA027;
	localparam logic [15:0] USED_COUNT = 16'h0013;
	localparam logic [15:0] OFS_ANALOG_IN_RANGE_FAULT = 16'h9C40;
	localparam logic [15:0] OFS_COUNT_IN_RANGE_FAULT = 16'h9C41;
	localparam logic [15:0] OFS_RATE_IN_RANGE_FAULT = 16'h9C42;
	localparam logic [15:0] OFS_ANALOG_IN_LOCAL_FORCE = 16'h9C43;
	localparam logic [15:0] OFS_SWITCH_IN_LOCAL_FORCE = 16'h9C44;
	localparam logic [15:0] OFS_COUNT_IN_LOCAL_FORCE = 16'h9C45;
	localparam logic [15:0] OFS_RATE_IN_LOCAL_FORCE = 16'h9C46;
	localparam logic [15:0] OFS_ANALOG_IN_REMOTE_FORCE_EN = 16'h9C47;
	localparam logic [15:0] OFS_SWITCH_IN_REMOTE_FORCE_EN = 16'h9C48;
	localparam logic [15:0] OFS_COUNT_IN_REMOTE_FORCE_EN = 16'h9C49;
	localparam logic [15:0] OFS_RATE_IN_REMOTE_FORCE_EN = 16'h9C4A;
	localparam logic [15:0] OFS_ANALOG_OUT_LOCAL_FORCE = 16'h9C4B;
	localparam logic [15:0] OFS_DIGITAL_OUT_LOCAL_FORCE = 16'h9C4C;
	localparam logic [15:0] OFS_ANALOG_OUT_ALARM_ACTIVE = 16'h9C4D;
	localparam logic [15:0] OFS_DIGITAL_OUT_ALARM_ACTIVE = 16'h9C4E;
	localparam logic [15:0] OFS_ANALOG_OUT_RECOPY_ACTIVE = 16'h9C4F;
	localparam logic [15:0] OFS_DIGITAL_OUT_RECOPY_ACTIVE = 16'h9C50;
	localparam logic [15:0] OFS_ANALOG_OUT_REMOTE_FORCE_EN = 16'h9C51;
	localparam logic [15:0] OFS_DIGITAL_OUT_REMOTE_FORCE_EN = 16'h9C52;
	localparam int GROUP_COUNT = 6;
	localparam int FIRST_OUT_GROUP = 4;
	localparam logic [5:0] IN_MASK = 6'h3F;
	localparam logic [5:0] OUT_MASK = 6'h0F;
	localparam logic [5:0] ENABLE_RESET = 6'h00;
	localparam logic [2:0] GROUP_ANALOG_IN = 3'h0;
	localparam logic [2:0] GROUP_SWITCH_IN = 3'h1;
	localparam logic [2:0] GROUP_COUNT_IN = 3'h2;
	localparam logic [2:0] GROUP_RATE_IN = 3'h3;
	localparam logic [2:0] GROUP_ANALOG_OUT = 3'h4;
	localparam logic [2:0] GROUP_DIGITAL_OUT = 3'h5;

	typedef struct packed {
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] wdata;
	} iosr_req_t;

	typedef struct packed {
		logic [15:0] rdata;
		logic [7:0] exc;
	} iosr_rsp_t;

	typedef struct packed {
		logic [5:0] analog_in_range;
		logic [5:0] count_in_range;
		logic [5:0] rate_in_range;
		logic [5:0] analog_in_local;
		logic [5:0] switch_in_local;
		logic [5:0] count_in_local;
		logic [5:0] rate_in_local;
		logic [3:0] analog_out_local;
		logic [3:0] digital_out_local;
		logic [3:0] analog_out_alarm;
		logic [3:0] digital_out_alarm;
		logic [3:0] analog_out_recopy;
		logic [3:0] digital_out_recopy;
	} iosr_status_t;

	typedef struct packed {
		logic [2:0] group;
		logic [2:0] channel;
		logic value_ok;
	} iosr_force_t;
endpackage
`default_nettype wire
